// File: design/tpsi_event_latch.sv
`timescale 1ns/1ns
module tpsi_event_latch (
  input  wire logic       core_clk,
  input  wire logic       rstSyncN,
  input  wire logic       swReset,
  input  wire logic [7:0] setEvents,
  input  wire logic       clrStrobe,
  input  wire logic [7:0] clrBits,
  output logic      [7:0] flags_ff
);

  logic [7:0] nxt_flags;

  // set wins over clear so an event landing on the read is kept
  always_comb begin
    nxt_flags = flags_ff;
    if (clrStrobe) begin
      nxt_flags = nxt_flags & ~clrBits;
    end
    nxt_flags = nxt_flags | setEvents;
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      flags_ff <= tpsi_pkg::RST_PD_IRQ;
    end else if (swReset) begin
      flags_ff <= tpsi_pkg::RST_PD_IRQ;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

endmodule

// File: design/tpsi_pkg.sv
package tpsi_pkg;

  // register port addresses
  localparam logic [7:0] ADDR_SW_RESET   = 8'h0C;
  localparam logic [7:0] ADDR_SETTLE_SOP = 8'h3D;
  localparam logic [7:0] ADDR_PD_IRQ     = 8'h3E;

  // reset values and unmapped read value
  localparam logic [7:0] RST_SETTLE_SOP  = 8'h00;
  localparam logic [7:0] RST_PD_IRQ      = 8'h00;
  localparam logic [7:0] RD_UNMAPPED     = 8'h00;

  // software reset register field
  localparam int unsigned SW_RESET_BIT   = 0;

  // settle/sop status fields
  localparam int unsigned SETTLE_LSB     = 3;
  localparam int unsigned SETTLE_MSB     = 5;
  localparam int unsigned DBLPRIME_DBG_BIT = 2;
  localparam int unsigned PRIME_DBG_BIT  = 1;
  localparam int unsigned PLAIN_SOP_BIT  = 0;

  // settle-state codes
  localparam logic [2:0] SETTLE_RUNNING  = 3'h0;
  localparam logic [2:0] SETTLE_SRC1     = 3'h1;
  localparam logic [2:0] SETTLE_SRC2     = 3'h2;
  localparam logic [2:0] SETTLE_SNK1     = 3'h5;
  localparam logic [2:0] SETTLE_SNK2     = 3'h6;
  localparam logic [2:0] SETTLE_AUDIO    = 3'h7;

  // interrupt bit positions
  localparam int unsigned IRQ_OVERCURRENT_HEAT  = 7;
  localparam int unsigned IRQ_TOGGLE_FINISHED   = 6;
  localparam int unsigned IRQ_SOFTRESET_FAILED  = 5;
  localparam int unsigned IRQ_RETRIES_EXHAUSTED = 4;
  localparam int unsigned IRQ_HARDRESET_SENT    = 3;
  localparam int unsigned IRQ_TX_ACKNOWLEDGED   = 2;
  localparam int unsigned IRQ_SOFTRESET_RX      = 1;
  localparam int unsigned IRQ_HARDRESET_RX      = 0;

  // start-of-packet type codes on the receive commit port
  typedef enum logic [2:0] {
    SOP_PLAIN        = 3'h0,
    SOP_PRIME        = 3'h1,
    SOP_DBLPRIME     = 3'h2,
    SOP_PRIME_DBG    = 3'h3,
    SOP_DBLPRIME_DBG = 3'h4
  } tpsi_sop_t;

  // toggle settle tracker states
  typedef enum logic [6:0] {
    TS_IDLE  = 7'h01,
    TS_RUN   = 7'h02,
    TS_SRC1  = 7'h04,
    TS_SRC2  = 7'h08,
    TS_SNK1  = 7'h10,
    TS_SNK2  = 7'h20,
    TS_AUDIO = 7'h40
  } tpsi_settle_state_t;

endpackage

// File: design/tpsi_settle_tracker.sv
`timescale 1ns/1ns
module tpsi_settle_tracker (
  input  wire logic       core_clk,
  input  wire logic       rstSyncN,
  input  wire logic       swReset,
  input  wire logic       toggleEnable,
  input  wire logic       halt_source_line1,
  input  wire logic       halt_source_line2,
  input  wire logic       halt_sink_line1,
  input  wire logic       halt_sink_line2,
  input  wire logic       audioAccessory,
  output logic      [2:0] settleCode_ff,
  output logic            toggleFinished
);

  tpsi_pkg::tpsi_settle_state_t state_ff;
  tpsi_pkg::tpsi_settle_state_t nxt_state;
  logic [2:0]                   nxt_settleCode;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tpsi_pkg::TS_IDLE: begin
        if (toggleEnable) begin
          nxt_state = tpsi_pkg::TS_RUN;
        end
      end
      tpsi_pkg::TS_RUN: begin
        if (!toggleEnable) begin
          nxt_state = tpsi_pkg::TS_IDLE;
        end else if (audioAccessory && halt_source_line1) begin
          nxt_state = tpsi_pkg::TS_AUDIO;
        end else if (halt_source_line1) begin
          nxt_state = tpsi_pkg::TS_SRC1;
        end else if (halt_source_line2) begin
          nxt_state = tpsi_pkg::TS_SRC2;
        end else if (halt_sink_line1) begin
          nxt_state = tpsi_pkg::TS_SNK1;
        end else if (halt_sink_line2) begin
          nxt_state = tpsi_pkg::TS_SNK2;
        end
      end
      default: begin
        // settled: held until software stops toggling
        if (!toggleEnable) begin
          nxt_state = tpsi_pkg::TS_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    case (nxt_state)
      tpsi_pkg::TS_SRC1:  nxt_settleCode = tpsi_pkg::SETTLE_SRC1;
      tpsi_pkg::TS_SRC2:  nxt_settleCode = tpsi_pkg::SETTLE_SRC2;
      tpsi_pkg::TS_SNK1:  nxt_settleCode = tpsi_pkg::SETTLE_SNK1;
      tpsi_pkg::TS_SNK2:  nxt_settleCode = tpsi_pkg::SETTLE_SNK2;
      tpsi_pkg::TS_AUDIO: nxt_settleCode = tpsi_pkg::SETTLE_AUDIO;
      default:            nxt_settleCode = tpsi_pkg::SETTLE_RUNNING;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_ff <= tpsi_pkg::TS_IDLE;
    end else if (swReset) begin
      state_ff <= tpsi_pkg::TS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      settleCode_ff <= tpsi_pkg::SETTLE_RUNNING;
    end else if (swReset) begin
      settleCode_ff <= tpsi_pkg::SETTLE_RUNNING;
    end else begin
      settleCode_ff <= nxt_settleCode;
    end
  end

  // one pulse when the run ends on a detected attach
  assign toggleFinished = (state_ff == tpsi_pkg::TS_RUN) && (nxt_state != tpsi_pkg::TS_RUN)
                          && (nxt_state != tpsi_pkg::TS_IDLE) && !swReset;

endmodule

// File: design/tpsi_status_irq_regs.sv
`timescale 1ns/1ns
module tpsi_status_irq_regs (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] regAddr,
  input  wire logic       regRdEn,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic            regRdValid,
  input  wire logic       toggleEnable,
  input  wire logic       halt_source_line1,
  input  wire logic       halt_source_line2,
  input  wire logic       halt_sink_line1,
  input  wire logic       halt_sink_line2,
  input  wire logic       audioAccessory,
  input  wire logic       rxCommit,
  input  wire logic [2:0] rxSopType,
  input  wire logic       overCurrentEvent,
  input  wire logic       overTempEvent,
  input  wire logic       softResetFailEvent,
  input  wire logic       retryFailEvent,
  input  wire logic       hardResetSentEvent,
  input  wire logic       txAckEvent,
  input  wire logic       softResetRxEvent,
  input  wire logic       hardResetRxEvent,
  input  wire logic [7:0] irqMask,
  output logic            software_reset_cmd,
  output logic            intN
);

  logic       rstMeta_ff;
  logic       rstSyncN_ff;
  logic       swReset_ff;
  logic       nxt_swReset;
  logic [2:0] settleCode;
  logic       toggleFinished;
  logic [2:0] sopFlags_ff;
  logic [7:0] irqEvents;
  logic [7:0] irqFlags;
  logic [7:0] statusWord;
  logic [7:0] nxt_rdData;
  logic       irqReadClear;
  logic [7:0] regRdData_ff;
  logic       regRdValid_ff;

  // receive sop type to the three status flags
  function automatic logic [2:0] sopToFlags(input logic [2:0] sopType);
    logic [2:0] f;
    f = 3'h0;
    if (sopType == tpsi_pkg::SOP_DBLPRIME_DBG) begin
      f[tpsi_pkg::DBLPRIME_DBG_BIT] = 1'b1;
    end else if (sopType == tpsi_pkg::SOP_PRIME_DBG) begin
      f[tpsi_pkg::PRIME_DBG_BIT] = 1'b1;
    end else if (sopType == tpsi_pkg::SOP_PLAIN) begin
      f[tpsi_pkg::PLAIN_SOP_BIT] = 1'b1;
    end
    return f;
  endfunction

  // reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_ff  <= 1'b0;
      rstSyncN_ff <= 1'b0;
    end else begin
      rstMeta_ff  <= 1'b1;
      rstSyncN_ff <= rstMeta_ff;
    end
  end

  // software reset command from a write to the reset register
  assign nxt_swReset = regWrEn && (regAddr == tpsi_pkg::ADDR_SW_RESET)
                       && regWrData[tpsi_pkg::SW_RESET_BIT];

  always_ff @(posedge core_clk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      swReset_ff <= 1'b0;
    end else begin
      swReset_ff <= nxt_swReset;
    end
  end

  assign software_reset_cmd = swReset_ff;

  tpsi_settle_tracker u_settle (
    .core_clk          (core_clk),
    .rstSyncN          (rstSyncN_ff),
    .swReset           (swReset_ff),
    .toggleEnable      (toggleEnable),
    .halt_source_line1 (halt_source_line1),
    .halt_source_line2 (halt_source_line2),
    .halt_sink_line1   (halt_sink_line1),
    .halt_sink_line2   (halt_sink_line2),
    .audioAccessory    (audioAccessory),
    .settleCode_ff     (settleCode),
    .toggleFinished    (toggleFinished)
  );

  // last packet committed to the receive fifo decides the sop flags
  always_ff @(posedge core_clk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      sopFlags_ff <= 3'h0;
    end else if (swReset_ff) begin
      sopFlags_ff <= 3'h0;
    end else if (rxCommit) begin
      sopFlags_ff <= sopToFlags(rxSopType);
    end
  end

  always_comb begin
    statusWord = tpsi_pkg::RST_SETTLE_SOP;
    statusWord[tpsi_pkg::SETTLE_MSB:tpsi_pkg::SETTLE_LSB] = settleCode;
    statusWord[tpsi_pkg::DBLPRIME_DBG_BIT] = sopFlags_ff[tpsi_pkg::DBLPRIME_DBG_BIT];
    statusWord[tpsi_pkg::PRIME_DBG_BIT]    = sopFlags_ff[tpsi_pkg::PRIME_DBG_BIT];
    statusWord[tpsi_pkg::PLAIN_SOP_BIT]    = sopFlags_ff[tpsi_pkg::PLAIN_SOP_BIT];
  end

  always_comb begin
    irqEvents = 8'h00;
    irqEvents[tpsi_pkg::IRQ_OVERCURRENT_HEAT]  = overCurrentEvent | overTempEvent;
    irqEvents[tpsi_pkg::IRQ_TOGGLE_FINISHED]   = toggleFinished;
    irqEvents[tpsi_pkg::IRQ_SOFTRESET_FAILED]  = softResetFailEvent;
    irqEvents[tpsi_pkg::IRQ_RETRIES_EXHAUSTED] = retryFailEvent;
    irqEvents[tpsi_pkg::IRQ_HARDRESET_SENT]    = hardResetSentEvent;
    irqEvents[tpsi_pkg::IRQ_TX_ACKNOWLEDGED]   = txAckEvent;
    irqEvents[tpsi_pkg::IRQ_SOFTRESET_RX]      = softResetRxEvent;
    irqEvents[tpsi_pkg::IRQ_HARDRESET_RX]      = hardResetRxEvent;
  end

  assign irqReadClear = regRdEn && (regAddr == tpsi_pkg::ADDR_PD_IRQ);

  tpsi_event_latch u_irq (
    .core_clk  (core_clk),
    .rstSyncN  (rstSyncN_ff),
    .swReset   (swReset_ff),
    .setEvents (irqEvents),
    .clrStrobe (irqReadClear),
    .clrBits   (irqFlags),
    .flags_ff  (irqFlags)
  );

  // register read decode
  always_comb begin
    if (regAddr == tpsi_pkg::ADDR_SETTLE_SOP) begin
      nxt_rdData = statusWord;
    end else if (regAddr == tpsi_pkg::ADDR_PD_IRQ) begin
      nxt_rdData = irqFlags;
    end else begin
      nxt_rdData = tpsi_pkg::RD_UNMAPPED;
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      regRdData_ff <= 8'h00;
    end else if (regRdEn) begin
      regRdData_ff <= nxt_rdData;
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      regRdValid_ff <= 1'b0;
    end else begin
      regRdValid_ff <= regRdEn;
    end
  end

  assign regRdData  = regRdData_ff;
  assign regRdValid = regRdValid_ff;

  assign intN = ~(|(irqFlags & ~irqMask));

endmodule

// File: verif/tb_tpsi_status_irq_regs.sv
`timescale 1ns/1ns
module tb_tpsi_status_irq_regs;
  logic       core_clk = 0, rst_n = 0, regRdEn = 0, regWrEn = 0, toggleEnable = 0, rxCommit = 0;
  logic [7:0] regAddr = 0, regWrData = 0, irqMask = 0, ev = 0, regRdData;
  logic [4:0] hv = 0;
  logic [2:0] rxSopType = 0;
  logic       regRdValid, software_reset_cmd, intN;
  logic [17:0] r;
  int         failures = 0, checks = 0, cycles = 0;
  // kind, stimulus, expected byte
  localparam logic [17:0] ROWS [18] = '{18'h08080, 18'h04080, 18'h02020, 18'h01010, 18'h00808, 18'h00404,
    18'h00202, 18'h00101, 18'h11838, 18'h10808, 18'h10410, 18'h10228, 18'h10130, 18'h20001, 18'h20100,
    18'h20200, 18'h20302, 18'h20404};
  tpsi_status_irq_regs dut (.core_clk, .rst_n, .regAddr, .regRdEn, .regWrEn, .regWrData, .regRdData,
    .regRdValid, .toggleEnable, .halt_source_line1(hv[3]), .halt_source_line2(hv[2]),
    .halt_sink_line1(hv[1]), .halt_sink_line2(hv[0]), .audioAccessory(hv[4]), .rxCommit, .rxSopType,
    .overCurrentEvent(ev[7]), .overTempEvent(ev[6]), .softResetFailEvent(ev[5]), .retryFailEvent(ev[4]),
    .hardResetSentEvent(ev[3]), .txAckEvent(ev[2]), .softResetRxEvent(ev[1]), .hardResetRxEvent(ev[0]),
    .irqMask, .software_reset_cmd, .intN);
  always #5 core_clk = ~core_clk;
  task automatic close_out;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out;
    end
  end
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      failures++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    regAddr = a;
    regRdEn = 1'h1;
    cyc(1);
    regRdEn = 1'h0;
    cmp({7'h00, regRdValid}, 8'h01);
    cmp(regRdData, e);
    // one idle edge so back-to-back reads never re-raise the strobe in the same step
    cyc(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'h1;
    cyc(1);
    regWrEn = 1'h0;
  endtask
  initial begin
    cyc(12);
    rst_n = 1'h1;
    cyc(3);
    rd(8'h3D, 8'h00);
    rd(8'h3E, 8'h00);
    for (int i = 0; i < 18; i++) begin
      r = ROWS[i];
      case (r[17:16])
        2'h0: begin
          ev = r[15:8];
          cyc(1);
          ev = 8'h00;
          cmp({7'h00, intN}, 8'h00);
          rd(8'h3E, r[7:0]);
          cmp({7'h00, intN}, 8'h01);
        end
        2'h1: begin
          toggleEnable = 1'h1;
          cyc(2);
          rd(8'h3D, 8'h00);
          hv = r[12:8];
          cyc(2);
          rd(8'h3D, r[7:0]);
          rd(8'h3E, 8'h40);
          hv = 5'h00;
          toggleEnable = 1'h0;
          cyc(2);
        end
        default: begin
          rxSopType = r[10:8];
          rxCommit = 1'h1;
          cyc(1);
          rxCommit = 1'h0;
          cyc(1);
          rd(8'h3D, r[7:0]);
        end
      endcase
    end
    irqMask = 8'hFF;
    ev = 8'hFF;
    cyc(1);
    ev = 8'h00;
    cmp({7'h00, intN}, 8'h01);
    irqMask = 8'h00;
    cyc(1);
    cmp({7'h00, intN}, 8'h00);
    wr(8'h3E, 8'h00);
    rd(8'h3E, 8'hBF);
    ev = 8'h01;
    cyc(1);
    ev = 8'h05;
    rd(8'h3E, 8'h01);
    ev = 8'h00;
    rd(8'h3E, 8'h05);
    rd(8'h55, 8'h00);
    ev = 8'h80;
    rxSopType = 3'h0;
    rxCommit = 1'h1;
    cyc(1);
    ev = 8'h00;
    rxCommit = 1'h0;
    wr(8'h0C, 8'h01);
    cmp({7'h00, software_reset_cmd}, 8'h01);
    cyc(1);
    rd(8'h3E, 8'h00);
    rd(8'h3D, 8'h00);
    ev = 8'h80;
    cyc(1);
    ev = 8'h00;
    rst_n = 1'h0;
    #1;
    cmp({7'h00, intN}, 8'h01);
    cyc(2);
    rst_n = 1'h1;
    cyc(3);
    rd(8'h3E, 8'h00);
    close_out;
  end
endmodule

// File: verif/tpsi_status_irq_regs_properties.sv
`timescale 1ns/1ns
module tpsi_status_irq_regs_chk (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] regAddr,
  input wire logic       regRdEn,
  input wire logic       regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic       regRdValid,
  input wire logic       rxCommit,
  input wire logic [2:0] rxSopType,
  input wire logic       overCurrentEvent,
  input wire logic       overTempEvent,
  input wire logic       txAckEvent,
  input wire logic       hardResetRxEvent,
  input wire logic [7:0] irqMask,
  input wire logic       software_reset_cmd,
  input wire logic       intN
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rdvalid; regRdEn |=> regRdValid; endproperty
  a_rdvalid: assert property (p_rdvalid) else $error("read answer missing");
  property p_ocp; (overCurrentEvent || overTempEvent) && !irqMask[7] && !software_reset_cmd ##1 !irqMask[7] |-> !intN;
  endproperty
  a_ocp: assert property (p_ocp) else $error("heat event not flagged");
  property p_tx; txAckEvent && !irqMask[2] && !software_reset_cmd ##1 !irqMask[2] |-> !intN; endproperty
  a_tx: assert property (p_tx) else $error("ack event not flagged");
  property p_hrx; hardResetRxEvent && !irqMask[0] && !software_reset_cmd ##1 !irqMask[0] |-> !intN; endproperty
  a_hrx: assert property (p_hrx) else $error("hard reset rx not flagged");
  property p_mask; irqMask == 8'hFF |-> intN; endproperty
  a_mask: assert property (p_mask) else $error("masked source drives output");
  property p_rdclr; regRdEn && regAddr == 8'h3E && !intN ##1 $stable(irqMask) |-> (regRdData & ~irqMask) != 8'h00;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("read lost pending flag");
  property p_sop; rxCommit && rxSopType == 3'h0 ##1 regRdEn && regAddr == 8'h3D && !rxCommit && !software_reset_cmd
    |=> regRdData[2:0] == 3'h1; endproperty
  a_sop: assert property (p_sop) else $error("plain start flag wrong");
  property p_hold; !intN && !regRdEn && !regWrEn && !software_reset_cmd ##1 $stable(irqMask) |-> !intN; endproperty
  a_hold: assert property (p_hold) else $error("flag dropped unread");
  property p_swr; regWrEn && regAddr == 8'h0C && regWrData[0] |=> software_reset_cmd ##1 intN; endproperty
  a_swr: assert property (p_swr) else $error("software reset failed");
  property p_code; $past(regRdEn) && $past(regAddr) == 8'h3D
    |-> regRdData[5:3] != 3'h3 && regRdData[5:3] != 3'h4 && regRdData[7:6] == 2'h0; endproperty
  a_code: assert property (p_code) else $error("undefined settle code shown");
endmodule
bind tpsi_status_irq_regs tpsi_status_irq_regs_chk chk (.core_clk, .rst_n, .regAddr, .regRdEn, .regWrEn, .regWrData,
  .regRdData, .regRdValid, .rxCommit, .rxSopType, .overCurrentEvent, .overTempEvent, .txAckEvent,
  .hardResetRxEvent, .irqMask, .software_reset_cmd, .intN);
